// >>> companion_link_regs.svh
// Register offsets, field positions, reset values and timing counts for the companion link master
//
// Operation
// - Master drives link clock; data line shared; start bit and turnaround in every message.
// - Block clocked from its source clock; system reset restores every register and state.
// - Busy cleared at end of transfer raises completion interrupt when its enable is set.
// - Error interrupt asserted whenever error flag and error enable are both one.
// - Busy low means low power; sleep is not blocked.
// - While a transfer runs, chip sleep is held off until idle again.
// - First data register read starts a link read and sets busy; returned value stale.
// - Read response byte loads the data register in the same cycle that busy clears.
// - No response within 16 link clocks: time out, error about 48 clocks later, clear busy.
// - Data register write launches a link write of address and byte, sets busy.
// - Write acknowledge clears busy and issues the completion interrupt.
// - Soft reset bit holds interface in reset; busy high about 48 link clocks; both default one.
// - Busy clearing after soft reset raises no completion interrupt.
// - CRC error or time-out sets error flag as busy clears; writing one clears it.
// - Link clock is source clock over divider field plus one (over two when the field is zero); field resets to 4.
// - Address register holds an eight-bit remote address for every transaction; resets to zero.
`ifndef COMPANION_LINK_REGS_SVH
`define COMPANION_LINK_REGS_SVH
`define OFS_LINK_STATUS_CONTROL 4'h0
`define OFS_REMOTE_ADDRESS      4'h4
`define OFS_TRANSFER_DATA       4'h8
`define OFS_LINK_CLOCK_DIVIDER  4'hC
`define BIT_BUSY                0
`define BIT_DONE_IRQ_ENABLE     4
`define BIT_ERROR_IRQ_ENABLE    5
`define BIT_LINK_ERROR_FLAG     6
`define BIT_SOFT_RESET          7
`define RST_DIVIDER             8'h04
`define RST_ADDRESS             8'h00
`define RST_DATA                8'h00
`define RESPONSE_TIMEOUT_TICKS  8'h10
`define ERROR_DELAY_TICKS       8'h30
`define SOFT_RESET_TICKS        8'h30
`define CRC_POLY                8'h07
`define HEADER_BITS             6'h12
`define WRITE_EXTRA_BITS        6'h08
`define READ_RESP_BITS          6'h10
`endif

// >>> companion_link_pkg.sv
// Types shared by the companion link master
`default_nettype none
package companion_link_pkg;
  typedef enum logic [2:0] {
    st_idle    = 3'b000,
    st_send    = 3'b001,
    st_turn    = 3'b011,
    st_wait    = 3'b010,
    st_recv    = 3'b110,
    st_err_gap = 3'b111,
    st_reset   = 3'b101
  } link_state_type;
endpackage : companion_link_pkg
`default_nettype wire

// >>> link_clock_gen.sv
// Link clock divider producing rising and falling edge ticks
`include "companion_link_regs.svh"
`default_nettype none
module link_clock_gen (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [7:0] divider,
  output logic            rise_tick,
  output logic            fall_tick,
  output logic            link_clock
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_link_clock;
  logic       wrap;
  logic       half;

  always_comb begin
    wrap            = (count >= divider);
    half            = (count == (divider >> 1));
    next_count      = wrap ? 8'h00 : 8'(count + 8'h01);
    next_link_clock = link_clock;
    rise_tick       = 1'b0;
    fall_tick       = 1'b0;
    if (!run) begin
      next_count      = 8'h00;
      next_link_clock = 1'b0;
    end else if (divider == 8'h00) begin
      // Divider zero: the link clock toggles every source clock cycle, dividing by two
      next_link_clock = ~link_clock;
      rise_tick       = ~link_clock;
      fall_tick       = link_clock;
    end else if (wrap) begin
      next_link_clock = 1'b1;
      rise_tick       = 1'b1;
    end else if (half) begin
      next_link_clock = 1'b0;
      fall_tick       = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count      <= 8'h00;
      link_clock <= 1'b0;
    end else begin
      count      <= next_count;
      link_clock <= next_link_clock;
    end
  end
endmodule : link_clock_gen
`default_nettype wire

// >>> crc8_step.sv
// One-bit step of the packet CRC
`include "companion_link_regs.svh"
`default_nettype none
module crc8_step (
  input  wire logic [7:0] crc_in,
  input  wire logic       bit_in,
  output logic      [7:0] crc_out
);
  always_comb begin
    crc_out = {crc_in[6:0], 1'b0} ^ ((crc_in[7] ^ bit_in) ? `CRC_POLY : 8'h00);
  end
endmodule : crc8_step
`default_nettype wire

// >>> companion_link_master.sv
// Companion link master: registers, packet engine and pin control
`include "companion_link_regs.svh"
`default_nettype none
module companion_link_master
  import companion_link_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             link_clock_out,
  input  wire logic        link_data_in,
  output logic             link_data_out,
  output logic             link_data_oe_n,
  output logic             link_irq,
  output logic             sleep_allow
);
  link_state_type state;
  link_state_type next_state;
  logic [7:0]  address;
  logic [7:0]  next_address;
  logic [7:0]  data;
  logic [7:0]  next_data;
  logic [7:0]  divider;
  logic [7:0]  next_divider;
  logic        busy;
  logic        next_busy;
  logic        soft_reset;
  logic        next_soft_reset;
  logic        error_flag;
  logic        next_error_flag;
  logic        err_en;
  logic        next_err_en;
  logic        done_en;
  logic        next_done_en;
  logic        done_pending;
  logic        next_done_pending;
  logic        is_write;
  logic        next_is_write;
  logic        crc_bad;
  logic        next_crc_bad;
  logic [25:0] shreg;
  logic [25:0] next_shreg;
  logic [5:0]  bits_left;
  logic [5:0]  next_bits_left;
  logic [7:0]  ticks;
  logic [7:0]  next_ticks;
  logic [7:0]  crc;
  logic [7:0]  next_crc;
  logic [7:0]  crc_stepped;
  logic        crc_bit;
  logic        drive;
  logic        next_drive;
  logic        dout;
  logic        next_dout;
  logic [31:0] next_rdata;
  logic        next_irq;
  logic        rise_tick;
  logic        fall_tick;
  logic        link_clock;
  logic        clock_run;
  logic        write_hit;
  logic        read_hit;

  assign clock_run = (state != st_idle);
  assign write_hit = reg_write;
  assign read_hit  = reg_read;

  link_clock_gen u_clock (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .run        (clock_run),
    .divider    (divider),
    .rise_tick  (rise_tick),
    .fall_tick  (fall_tick),
    .link_clock (link_clock)
  );

  crc8_step u_crc (
    .crc_in  (crc),
    .bit_in  (crc_bit),
    .crc_out (crc_stepped)
  );

  // CRC covers bits sent and bits received alike
  assign crc_bit = (state == st_recv) ? link_data_in : shreg[25];

  always_comb begin
    next_state        = state;
    next_address      = address;
    next_data         = data;
    next_divider      = divider;
    next_busy         = busy;
    next_soft_reset   = soft_reset;
    next_error_flag   = error_flag;
    next_err_en       = err_en;
    next_done_en      = done_en;
    next_done_pending = 1'b0;
    next_is_write     = is_write;
    next_crc_bad      = crc_bad;
    next_shreg        = shreg;
    next_bits_left    = bits_left;
    next_ticks        = ticks;
    next_crc          = crc;
    next_drive        = drive;
    next_dout         = dout;
    next_rdata        = 32'h0000_0000;

    // Register read path; reserved bits read zero
    if (read_hit) begin
      unique case (reg_addr)
        `OFS_LINK_STATUS_CONTROL: next_rdata = {24'h000000, soft_reset, error_flag, err_en, done_en, 3'b000, busy};
        `OFS_REMOTE_ADDRESS:      next_rdata = {24'h000000, address};
        `OFS_TRANSFER_DATA:       next_rdata = {24'h000000, data};
        `OFS_LINK_CLOCK_DIVIDER:  next_rdata = {24'h000000, divider};
        default:                  next_rdata = 32'h0000_0000;
      endcase
    end

    // Register write path
    if (write_hit) begin
      unique case (reg_addr)
        `OFS_LINK_STATUS_CONTROL: begin
          next_soft_reset = reg_wdata[`BIT_SOFT_RESET];
          next_err_en     = reg_wdata[`BIT_ERROR_IRQ_ENABLE];
          next_done_en    = reg_wdata[`BIT_DONE_IRQ_ENABLE];
          if (reg_wdata[`BIT_LINK_ERROR_FLAG]) begin
            next_error_flag = 1'b0;
          end
          if (reg_wdata[`BIT_SOFT_RESET]) begin
            next_busy = 1'b1;
          end
        end
        `OFS_REMOTE_ADDRESS: next_address = reg_wdata[7:0];
        `OFS_TRANSFER_DATA:  next_data = reg_wdata[7:0];
        `OFS_LINK_CLOCK_DIVIDER: next_divider = reg_wdata[7:0];
        default: ;
      endcase
    end

    // Link engine
    if (soft_reset || (write_hit && reg_addr == `OFS_LINK_STATUS_CONTROL && reg_wdata[`BIT_SOFT_RESET])) begin
      // Held in reset; busy already set, countdown starts once released
      next_state = st_reset;
      next_ticks = `SOFT_RESET_TICKS;
      next_drive = 1'b0;
      next_dout  = 1'b1;
    end else begin
      unique case (state)
        st_idle: begin
          if (write_hit && reg_addr == `OFS_TRANSFER_DATA) begin
            next_is_write  = 1'b1;
            next_busy      = 1'b1;
            next_state     = st_send;
            next_shreg     = {1'b1, 1'b1, address, reg_wdata[7:0], 8'h00};
            next_bits_left = 6'(`HEADER_BITS + `WRITE_EXTRA_BITS) - 6'h08;
            next_crc       = 8'h00;
            next_crc_bad   = 1'b0;
          end else if (read_hit && reg_addr == `OFS_TRANSFER_DATA) begin
            next_is_write  = 1'b0;
            next_busy      = 1'b1;
            next_state     = st_send;
            next_shreg     = {1'b1, 1'b0, address, 16'h0000};
            next_bits_left = `HEADER_BITS - 6'h08;
            next_crc       = 8'h00;
            next_crc_bad   = 1'b0;
          end
        end
        st_send: begin
          if (fall_tick) begin
            // Data changes on the falling edge, companion samples on the rising edge
            next_drive = 1'b1;
            if (bits_left == 6'h00) begin
              // Append the CRC, then release the line
              next_dout      = crc[7];
              next_shreg     = {crc[6:0], 19'h00000};
              next_bits_left = 6'h07;
              next_crc       = 8'h00;
              next_state     = st_turn;
            end else begin
              next_dout      = shreg[25];
              next_crc       = crc_stepped;
              next_shreg     = {shreg[24:0], 1'b0};
              next_bits_left = 6'(bits_left - 6'h01);
            end
          end
        end
        st_turn: begin
          if (fall_tick) begin
            if (bits_left == 6'h00) begin
              next_drive = 1'b0;
              next_state = st_wait;
              next_ticks = `RESPONSE_TIMEOUT_TICKS;
            end else begin
              next_dout      = shreg[25];
              next_shreg     = {shreg[24:0], 1'b0};
              next_bits_left = 6'(bits_left - 6'h01);
            end
          end
        end
        st_wait: begin
          if (rise_tick) begin
            if (!link_data_in) begin
              // Start bit of the response, driven low by the companion
              next_state     = st_recv;
              next_bits_left = `READ_RESP_BITS;
              next_crc       = 8'h00;
              next_shreg     = 26'h0000000;
            end else if (ticks == 8'h01) begin
              next_crc_bad = 1'b1;
              next_state   = st_err_gap;
              next_ticks   = `ERROR_DELAY_TICKS;
            end else begin
              next_ticks = 8'(ticks - 8'h01);
            end
          end
        end
        st_recv: begin
          if (rise_tick) begin
            // Response: data byte then CRC; a write ack carries the written byte
            next_shreg     = {shreg[24:0], link_data_in};
            next_crc       = crc_stepped;
            next_bits_left = 6'(bits_left - 6'h01);
            if (bits_left == 6'h01) begin
              if (crc_stepped != 8'h00) begin
                next_state = st_err_gap;
                next_ticks = `ERROR_DELAY_TICKS;
                next_crc_bad = 1'b1;
              end else begin
                if (!is_write) begin
                  next_data = shreg[14:7];
                end
                next_busy         = 1'b0;
                next_done_pending = 1'b1;
                next_state        = st_idle;
              end
            end
          end
        end
        st_err_gap: begin
          if (rise_tick) begin
            if (ticks == 8'h01) begin
              next_error_flag   = crc_bad;
              next_busy         = 1'b0;
              next_done_pending = 1'b1;
              next_state        = st_idle;
            end else begin
              next_ticks = 8'(ticks - 8'h01);
            end
          end
        end
        st_reset: begin
          if (rise_tick) begin
            if (ticks == 8'h01) begin
              next_busy  = 1'b0;
              next_state = st_idle;
            end else begin
              next_ticks = 8'(ticks - 8'h01);
            end
          end
        end
        default: next_state = st_idle;
      endcase
    end

    next_irq = (done_pending && done_en) || (next_error_flag && next_err_en);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state          <= st_reset;
      address        <= `RST_ADDRESS;
      data           <= `RST_DATA;
      divider        <= `RST_DIVIDER;
      busy           <= 1'b1;
      soft_reset     <= 1'b1;
      error_flag     <= 1'b0;
      err_en         <= 1'b0;
      done_en        <= 1'b0;
      done_pending   <= 1'b0;
      is_write       <= 1'b0;
      crc_bad        <= 1'b0;
      shreg          <= 26'h0000000;
      bits_left      <= 6'h00;
      ticks          <= `SOFT_RESET_TICKS;
      crc            <= 8'h00;
      drive          <= 1'b0;
      dout           <= 1'b1;
      reg_rdata      <= 32'h0000_0000;
      link_irq       <= 1'b0;
      link_clock_out <= 1'b0;
      link_data_out  <= 1'b1;
      link_data_oe_n <= 1'b1;
      sleep_allow    <= 1'b0;
    end else begin
      state          <= next_state;
      address        <= next_address;
      data           <= next_data;
      divider        <= next_divider;
      busy           <= next_busy;
      soft_reset     <= next_soft_reset;
      error_flag     <= next_error_flag;
      err_en         <= next_err_en;
      done_en        <= next_done_en;
      done_pending   <= next_done_pending;
      is_write       <= next_is_write;
      crc_bad        <= next_crc_bad;
      shreg          <= next_shreg;
      bits_left      <= next_bits_left;
      ticks          <= next_ticks;
      crc            <= next_crc;
      drive          <= next_drive;
      dout           <= next_dout;
      reg_rdata      <= next_rdata;
      link_irq       <= next_irq;
      link_clock_out <= clock_run && (rise_tick || (link_clock && !fall_tick));
      link_data_out  <= next_dout;
      link_data_oe_n <= ~next_drive;
      sleep_allow    <= ~busy;
    end
  end
endmodule : companion_link_master
`default_nettype wire

// >>> companion_link_master_assertions.sv
// Port-level assertions for the companion link master
`default_nettype none
module companion_link_master_assertions (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        link_clock_out,
  input wire logic        link_data_out,
  input wire logic        link_data_oe_n,
  input wire logic        link_irq,
  input wire logic        sleep_allow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic st_wr;
  assign st_wr = reg_write && reg_addr == 4'h0;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_rdata_unused_zero: assert property ((!reg_read || reg_addr[1:0] != 2'h0) |=> reg_rdata == 32'h0)
    else $error("read data not zero");
  a_reserved_bits_zero: assert property (reg_read |=> reg_rdata[31:8] == 24'h0)
    else $error("reserved bits not zero");
  a_drive_blocks_sleep: assert property (!link_data_oe_n |-> !sleep_allow)
    else $error("sleep allowed while driving");
  a_clock_blocks_sleep: assert property ($rose(link_clock_out) |-> !sleep_allow)
    else $error("sleep allowed while clocking");
  a_idle_released: assert property (sleep_allow [*2] |-> link_data_oe_n && !link_clock_out)
    else $error("link active while idle");
  a_start_marker: assert property ($fell(link_data_oe_n) |-> link_data_out)
    else $error("packet does not open with marker");
  a_transfer_busy: assert property ((reg_read || reg_write) && reg_addr == 4'h8 && sleep_allow
    |-> ##[1:3] !sleep_allow [*4]) else $error("transfer did not set busy");
  a_soft_reset_busy: assert property (st_wr && reg_wdata[7] |-> ##[1:3] !sleep_allow [*8])
    else $error("soft reset did not set busy");
  a_irq_off_disabled: assert property (st_wr && reg_wdata[5:4] == 2'h0 |-> ##2 !link_irq)
    else $error("interrupt while disabled");
  a_err_clear_quiet: assert property (st_wr && reg_wdata[6] && !reg_wdata[4] && sleep_allow |-> ##2 !link_irq)
    else $error("interrupt after error clear");
  cover property ($rose(link_irq));
  cover property ($fell(link_data_oe_n));
  cover property (reg_read && reg_addr == 4'h8 && sleep_allow);
endmodule : companion_link_master_assertions
bind companion_link_master companion_link_master_assertions u_companion_link_master_assertions (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_clock_out(link_clock_out), .link_data_out(link_data_out),
  .link_data_oe_n(link_data_oe_n), .link_irq(link_irq), .sleep_allow(sleep_allow));
`default_nettype wire

// >>> companion_model.sv
// Behavioural companion chip on the far side of the two-wire link
`default_nettype none
module companion_model (
  input  wire logic        clk_sys,
  input  wire logic        link_clock_out,
  input  wire logic        link_data_oe_n,
  input  wire logic        link_data_out,
  input  wire logic [1:0]  mode,
  input  wire logic [3:0]  resp_delay,
  output logic             link_data_in,
  output logic      [25:0] last_frame,
  output int               bad_frames
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       drive_en, drive_val;
  logic [7:0] mem [256];
  logic [7:0] ad, dt;
  int         nbits, n;
  function automatic logic [7:0] crc_of(input logic [25:0] f, input int k);
    logic [7:0] c;
    c = 8'h00;
    for (int i = k - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ f[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc_of
  task automatic respond(input logic [7:0] b);
    logic [15:0] r;
    r = {b, crc_of({18'h0, b}, 8) ^ {7'h0, mode == 2'h2}};
    repeat (resp_delay) @(negedge link_clock_out);
    drive_val = 1'b0;
    drive_en = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(negedge link_clock_out);
      drive_val = r[i];
    end
    @(posedge link_clock_out);
    repeat (2) @(posedge clk_sys);
    drive_en = 1'b0;
  endtask : respond
  initial begin
    drive_en = 1'b0;
    drive_val = 1'b1;
    nbits = 0;
    bad_frames = 0;
    last_frame = '0;
    for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
  end
  // Master, else companion, else the pull-up
  assign link_data_in = !link_data_oe_n ? link_data_out : (drive_en ? drive_val : 1'b1);
  always @(posedge link_clock_out) begin
    if (link_data_oe_n === 1'b0) begin
      last_frame = {last_frame[24:0], link_data_out};
      nbits++;
    end
  end
  always @(posedge link_data_oe_n) begin
    n = nbits;
    nbits = 0;
    if (n > 0) begin
      if ((n != 18 && n != 26) || !last_frame[n - 1] || last_frame[n - 2] != (n == 26)
          || crc_of(last_frame, n) != 8'h00)
        bad_frames++;
      else if (mode != 2'h1) begin
        ad = last_frame[n - 3 -: 8];
        dt = last_frame[15:8];
        if (n == 26) mem[ad] = dt;
        else dt = mem[ad];
        respond(dt);
      end
    end
  end
endmodule : companion_model
`default_nettype wire

// >>> companion_link_master_bench.sv
// Self-checking bench for the companion link master
`default_nettype none
module companion_link_master_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_n, reg_write, reg_read, link_clock_out, link_data_in;
  logic        link_data_out, link_data_oe_n, link_irq, sleep_allow, irq_q;
  logic [3:0]  reg_addr, resp_delay;
  logic [31:0] reg_wdata, reg_rdata, seed, rd;
  logic [1:0]  mode;
  logic [25:0] frame;
  logic [7:0]  shadow [256];
  logic [7:0]  div, a, d;
  logic [3:0]  ofs [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h1};
  logic [31:0] exp_rst [5] = '{32'h81, 32'h0, 32'h0, 32'h4, 32'h0};
  int          bad_count, checked, irq_rises, bad_frames;
  time         link_period, last_rise, rel_t;
  companion_link_master u_companion_link_master (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .link_clock_out(link_clock_out), .link_data_in(link_data_in), .link_data_out(link_data_out),
    .link_data_oe_n(link_data_oe_n), .link_irq(link_irq), .sleep_allow(sleep_allow));
  companion_model u_companion_model (.clk_sys(clk_sys), .link_clock_out(link_clock_out),
    .link_data_oe_n(link_data_oe_n), .link_data_out(link_data_out), .mode(mode), .resp_delay(resp_delay),
    .link_data_in(link_data_in), .last_frame(frame), .bad_frames(bad_frames));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge link_clock_out) begin
    link_period = $time - last_rise;
    last_rise = $time;
  end
  always @(posedge link_data_oe_n) rel_t = $time;
  always @(posedge clk_sys) begin
    if (link_irq === 1'b1 && irq_q !== 1'b1) irq_rises++;
    irq_q = link_irq;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] ad, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rdreg(input logic [3:0] ad, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rdreg
  task automatic wait_idle(output int n);
    repeat (3) @(posedge clk_sys);
    n = 3;
    while (sleep_allow !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > 20000) begin
        bad_count++;
        $display("Error at %0t: wait for idle ran out", $time);
        print_verdict();
      end
    end
  endtask : wait_idle
  task automatic soft_reset();
    int n;
    wr(4'h0, 32'hB0);
    div = 8'(rnd() % 6 + 1);
    wr(4'hC, {24'h0, div});
    irq_rises = 0;
    wr(4'h0, 32'hFFFF_FF3E);
    wait_idle(n);
    check(32'(irq_rises), 32'h0);
    check(32'(n >= 46 * (div + 1) && n <= 54 * (div + 1)), 32'h1);
    rdreg(4'hC, rd);
    check(rd, {24'h0, div});
  endtask : soft_reset
  task automatic xfer(input logic is_wr, input logic [1:0] md, input logic [3:0] dl);
    int n;
    logic [31:0] v;
    mode = md;
    resp_delay = dl;
    a = 8'(rnd());
    d = 8'(rnd());
    wr(4'h4, {24'h0, a});
    irq_rises = 0;
    if (is_wr) wr(4'h8, {24'h0, d});
    else rdreg(4'h8, v);
    rdreg(4'h0, v);
    check(32'(v[0]), 32'h1);
    wait_idle(n);
    if (is_wr) check(32'(frame[25:8]), {14'h0, 2'b11, a, d});
    else check(32'(frame[17:8]), {22'h0, 2'b10, a});
    rdreg(4'h0, v);
    check(v, md == 2'h0 ? 32'h30 : 32'h70);
    if (is_wr && md != 2'h1) shadow[a] = d;
    if (md == 2'h0) begin
      check(32'(irq_rises), 32'h1);
      check(32'(link_period), 32'((div + 1) * 50));
      rdreg(4'h8, v);
      check(v, {24'h0, shadow[a]});
      wait_idle(n);
    end else begin
      if (md == 2'h1) check(32'((($time - rel_t) / ((div + 1) * 50)) inside {[60:70]}), 32'h1);
      check(32'(link_irq), 32'h1);
      wr(4'h0, 32'h60);
      rdreg(4'h0, v);
      check(v, 32'h20);
      check(32'(link_irq), 32'h0);
      soft_reset();
    end
  endtask : xfer
  initial begin
    seed = 32'hD2DC;
    rst_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    mode = 2'h0;
    resp_delay = 4'h2;
    div = 8'h04;
    for (int i = 0; i < 256; i++) shadow[i] = ~8'(i);
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1 check(32'(sleep_allow), 32'h0);
    wr(4'h1, 32'hFFFF_FFFF);
    foreach (ofs[i]) begin
      rdreg(ofs[i], rd);
      check(rd, exp_rst[i]);
    end
    $display("reset value test done");
    soft_reset();
    $display("soft reset test done");
    for (int k = 0; k < 14; k++) begin
      rd = rnd();
      xfer(k < 6 ? !k[0] : rd[0], k < 6 ? 2'(k / 2) : 2'h0, 4'(2 + rd[3:1]));
      $display("transfer test %0d done", k);
    end
    check(32'(bad_frames), 32'h0);
    print_verdict();
  end
endmodule : companion_link_master_bench
`default_nettype wire
